// file: hdl/lpb_pal_ram.sv
// dual-port palette memory: byte-lane writes on port a, reads on both ports
// assumes synchronous read, one cycle from enable to data
`timescale 1ns/1ps
module lpb_pal_ram
#(
    parameter int DEPTH = 256,
    parameter int WIDTH = 25
)(
    input wire logic clk,
    input wire logic a_en,
    input wire logic a_we,
    input wire logic [3:0] a_be,
    input wire logic [$clog2(DEPTH)-1:0] a_addr,
    input wire logic [WIDTH-1:0] a_wdata,
    output logic [WIDTH-1:0] a_rdata,
    input wire logic b_en,
    input wire logic [$clog2(DEPTH)-1:0] b_addr,
    output logic [WIDTH-1:0] b_rdata
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] wmask;

    if (WIDTH > 32 || DEPTH < 2)
    begin : g_bad
        $error("palette ram width or depth not supported");
    end

    // byte enable spread over the entry bits
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_mask
        assign wmask[i] = a_be[i / 8];
    end

    always_ff @(posedge clk)
    begin
        if (a_en && a_we)
        begin
            mem[a_addr] <= (mem[a_addr] & ~wmask) | (a_wdata & wmask);
        end
        if (a_en && !a_we)
        begin
            a_rdata <= mem[a_addr];
        end
    end

    always_ff @(posedge clk)
    begin
        if (b_en)
        begin
            b_rdata <= mem[b_addr];
        end
    end
endmodule

// file: hdl/lpb_pkg.sv
// constants, field layouts and encodings for the pixel palette / blend stage
// assumes one 200 MHz clock and a 32-bit classic Wishbone register port
package lpb_pkg;
    localparam int ADDR_W = 12;
    localparam int PAL_DEPTH = 256;
    localparam int PAL_ENTRY_W = 25;
    localparam int SER_BEATS = 3;

    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_ALPHA_VALUE_ZERO = 12'h004;
    localparam logic [11:0] OFS_ALPHA_VALUE_ONE = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;
    localparam logic [1:0] PAL_BASE_PAGE = 2'h1;
    localparam logic [1:0] PAL_OVL_PAGE = 2'h2;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_BFMT_LSB = 4;
    localparam int CTRL_OFMT_LSB = 8;
    localparam int CTRL_PPBLEND_BIT = 12;
    localparam int CTRL_OVL_EN_BIT = 13;
    localparam int STAT_VPH_LSB = 0;
    localparam int STAT_VIOL_BIT = 8;

    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [2:0] FMT_RST = 3'h0;
    localparam logic PPBLEND_RST = 1'b0;
    localparam logic OVL_EN_RST = 1'b0;
    localparam logic [7:0] ALPHA_RST = 8'h00;
    localparam logic [1:0] VPH_ACTIVE = 2'h2;

    typedef enum logic [2:0] {
        MODE_PAR24 = 3'h0,
        MODE_PAR18 = 3'h1,
        MODE_PAR16 = 3'h2,
        MODE_SER24 = 3'h3,
        MODE_SER18 = 3'h4,
        MODE_CPU18 = 3'h5,
        MODE_CPU16 = 3'h6
    } lpb_mode_t;

    typedef enum logic [2:0] {
        FMT_888 = 3'h0,
        FMT_666 = 3'h1,
        FMT_565 = 3'h2,
        FMT_555 = 3'h5
    } lpb_fmt_t;
endpackage

// file: hdl/lpb_top.sv
// pixel formatting stage: two palettes, overlay blend, video pin mapping
// assumes pixel indices from same-clock fetch logic, registers over Wishbone
`timescale 1ns/1ps
module lpb_top
    import lpb_pkg::*;
#(
    parameter int PAL_DEPTH_P = PAL_DEPTH,
    parameter int ENTRY_W_P = PAL_ENTRY_W
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADDR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic [1:0] vertical_phase_field,
    input wire logic pix_valid,
    input wire logic [7:0] base_index,
    input wire logic [7:0] ovl_index,
    input wire logic ovl_cover,
    output logic [23:0] video_data_pins,
    output logic video_data_valid
);
    if (PAL_DEPTH_P != 256 || ENTRY_W_P != 25)
    begin : g_bad
        $error("palette must be 256 entries of 25 bits");
    end

    logic ack_q;
    logic rd_wait_q;
    logic [31:0] dat_q;
    logic [2:0] mode_q;
    logic [2:0] bfmt_q;
    logic [2:0] ofmt_q;
    logic pp_q;
    logic ovl_en_q;
    logic [7:0] alpha_value_zero_q [3];
    logic [7:0] alpha_value_one_q [3];
    logic viol_q;
    logic req;
    logic pal_hit;
    logic pal_rd;
    logic reg_wr;
    logic [24:0] pal_a_rd [2];
    logic [24:0] pal_b_rd [2];
    logic v1_q;
    logic cov1_q;
    logic v2_q;
    logic cov2_q;
    logic oaen2_q;
    logic [7:0] base2_q [3];
    logic [7:0] ovl2_q [3];
    logic v3_q;
    logic [7:0] mix3_q [3];
    logic [7:0] hold_q [3];
    logic [1:0] beat_q;
    logic run_q;
    logic [23:0] vd_q;
    logic vd_valid_q;
    logic [24:0] bun;
    logic [24:0] oun;
    logic serial;

    assign wb_ack = ack_q;
    assign wb_dat_r = dat_q;
    assign video_data_pins = vd_q;
    assign video_data_valid = vd_valid_q;

    // bus decode
    assign req = wb_cyc && wb_stb && !ack_q;
    assign pal_hit = wb_adr[11:10] == PAL_BASE_PAGE || wb_adr[11:10] == PAL_OVL_PAGE;
    assign pal_rd = pal_hit && !wb_we;
    assign reg_wr = req && wb_we && !pal_hit;
    assign serial = mode_q == MODE_SER24 || mode_q == MODE_SER18;

    // palette reads take one extra cycle for the synchronous ram
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
            rd_wait_q <= 1'b0;
        end
        else
        begin
            ack_q <= req && (!pal_rd || rd_wait_q);
            rd_wait_q <= req && pal_rd && !rd_wait_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dat_q <= 32'h0000_0000;
        end
        else if (req && !wb_we && (!pal_rd || rd_wait_q))
        begin
            dat_q <= 32'h0000_0000;
            if (pal_hit)
            begin
                dat_q <= {7'h00, pal_a_rd[wb_adr[11]]};
            end
            else
            begin
                case (wb_adr)
                    OFS_CTRL: dat_q <= {18'h0, ovl_en_q, pp_q, 1'b0, ofmt_q, 1'b0, bfmt_q,
                        1'b0, mode_q};
                    OFS_ALPHA_VALUE_ZERO: dat_q <= {8'h00, alpha_value_zero_q[0], alpha_value_zero_q[1], alpha_value_zero_q[2]};
                    OFS_ALPHA_VALUE_ONE: dat_q <= {8'h00, alpha_value_one_q[0], alpha_value_one_q[1], alpha_value_one_q[2]};
                    OFS_STATUS: dat_q <= {23'h0, viol_q, 6'h00, vertical_phase_field};
                    default: dat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= MODE_RST;
            bfmt_q <= FMT_RST;
            ofmt_q <= FMT_RST;
            pp_q <= PPBLEND_RST;
            ovl_en_q <= OVL_EN_RST;
        end
        else if (reg_wr && wb_adr == OFS_CTRL)
        begin
            if (wb_sel[0])
            begin
                mode_q <= wb_dat_w[CTRL_MODE_LSB +: 3];
                bfmt_q <= wb_dat_w[CTRL_BFMT_LSB +: 3];
            end
            if (wb_sel[1])
            begin
                ofmt_q <= wb_dat_w[CTRL_OFMT_LSB +: 3];
                pp_q <= wb_dat_w[CTRL_PPBLEND_BIT];
                ovl_en_q <= wb_dat_w[CTRL_OVL_EN_BIT];
            end
        end
    end

    // channel c sits in byte lane 2-c (red highest)
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int c = 0; c < 3; c++)
            begin
                alpha_value_zero_q[c] <= ALPHA_RST;
                alpha_value_one_q[c] <= ALPHA_RST;
            end
        end
        else
        begin
            for (int c = 0; c < 3; c++)
            begin
                if (reg_wr && wb_adr == OFS_ALPHA_VALUE_ZERO && wb_sel[2 - c])
                begin
                    alpha_value_zero_q[c] <= wb_dat_w[8 * (2 - c) +: 8];
                end
                if (reg_wr && wb_adr == OFS_ALPHA_VALUE_ONE && wb_sel[2 - c])
                begin
                    alpha_value_one_q[c] <= wb_dat_w[8 * (2 - c) +: 8];
                end
            end
        end
    end

    // sticky flag: palette touched in active phase; set beats clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            viol_q <= 1'b0;
        end
        else
        begin
            viol_q <= (req && pal_hit && vertical_phase_field == VPH_ACTIVE)
                || (viol_q && !(reg_wr && wb_adr == OFS_STATUS && wb_sel[1]
                && wb_dat_w[STAT_VIOL_BIT]));
        end
    end

    // one palette per layer
    for (genvar w = 0; w < 2; w++)
    begin : g_pal
        lpb_pal_ram #(
            .DEPTH(PAL_DEPTH_P),
            .WIDTH(ENTRY_W_P)
        ) u_ram (
            .clk(clk),
            .a_en(req && pal_hit && wb_adr[11] == 1'(w) && (wb_we || !rd_wait_q)),
            .a_we(wb_we),
            .a_be(wb_sel),
            .a_addr(wb_adr[9:2]),
            .a_wdata(wb_dat_w[24:0]),
            .a_rdata(pal_a_rd[w]),
            .b_en(pix_valid),
            .b_addr(w == 0 ? base_index : ovl_index),
            .b_rdata(pal_b_rd[w])
        );
    end

    // entry to {alpha select, r8, g8, b8}, channels left aligned
    function automatic logic [24:0] unpack(input logic [24:0] e, input logic [2:0] fmt);
        logic [24:0] u;
        u = e;
        case (fmt)
            FMT_888: u = e;
            FMT_666: u = {e[18], e[17:12], 2'h0, e[11:6], 2'h0, e[5:0], 2'h0};
            FMT_565: u = {1'b0, e[15:11], 3'h0, e[10:5], 2'h0, e[4:0], 3'h0};
            FMT_555: u = {e[15], e[14:10], 3'h0, e[9:5], 3'h0, e[4:0], 3'h0};
            default: u = e;
        endcase
        return u;
    endfunction

    assign bun = unpack(pal_b_rd[0], bfmt_q);
    assign oun = unpack(pal_b_rd[1], ofmt_q);

    // stages 1 and 2: lookup then unpack
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            v1_q <= 1'b0;
            cov1_q <= 1'b0;
            v2_q <= 1'b0;
            cov2_q <= 1'b0;
            oaen2_q <= 1'b0;
            for (int c = 0; c < 3; c++)
            begin
                base2_q[c] <= 8'h00;
                ovl2_q[c] <= 8'h00;
            end
        end
        else
        begin
            v1_q <= pix_valid;
            cov1_q <= pix_valid && ovl_cover && ovl_en_q;
            v2_q <= v1_q;
            cov2_q <= cov1_q;
            oaen2_q <= oun[24];
            for (int c = 0; c < 3; c++)
            begin
                base2_q[c] <= bun[23 - 8 * c -: 8];
                ovl2_q[c] <= oun[23 - 8 * c -: 8];
            end
        end
    end

    // stage 3: per-channel blend, overlay on top where it covers
    for (genvar c = 0; c < 3; c++)
    begin : g_ch
        logic [7:0] f;
        logic [8:0] w;
        logic [15:0] pb;
        logic [15:0] po;
        assign f = (pp_q && oaen2_q) ? alpha_value_one_q[c] : alpha_value_zero_q[c];
        assign w = {1'b0, f} + {8'h00, f[7]};
        assign pb = 16'(base2_q[c]) * 16'(9'h100 - w);
        assign po = 16'(ovl2_q[c]) * 16'(w);

        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                mix3_q[c] <= 8'h00;
            end
            else
            begin
                mix3_q[c] <= cov2_q ? 8'((pb + po) >> 8) : base2_q[c];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            v3_q <= 1'b0;
        end
        else
        begin
            v3_q <= v2_q;
        end
    end

    function automatic logic [23:0] ser_place(input logic [7:0] ch, input logic [2:0] m);
        logic [23:0] o;
        o = {ch, 16'h0000};
        if (m == MODE_SER18)
        begin
            o = {ch[7:2], 18'h00000};
        end
        return o;
    endfunction

    function automatic logic [23:0] par_place(input logic [7:0] r, input logic [7:0] g,
        input logic [7:0] b, input logic [2:0] m);
        logic [23:0] o;
        o = {r, g, b};
        case (m)
            MODE_PAR18: o = {r[7:2], 2'h0, g[7:2], 2'h0, b[7:2], 2'h0};
            MODE_PAR16: o = {r[7:3], 3'h0, g[7:2], 2'h0, b[7:3], 3'h0};
            MODE_CPU18: o = {6'h00, r[7:2], g[7:2], b[7:2]};
            MODE_CPU16: o = {6'h00, r[7:3], g[7:2], b[7:3], 2'h0};
            default: o = {r, g, b};
        endcase
        return o;
    endfunction

    // stage 4: pin map, serial modes spread a pixel over three beats
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vd_q <= 24'h00_0000;
            vd_valid_q <= 1'b0;
            beat_q <= 2'h0;
            run_q <= 1'b0;
            for (int c = 0; c < 3; c++)
            begin
                hold_q[c] <= 8'h00;
            end
        end
        else if (v3_q)
        begin
            vd_valid_q <= 1'b1;
            beat_q <= 2'h0;
            run_q <= serial;
            for (int c = 0; c < 3; c++)
            begin
                hold_q[c] <= mix3_q[c];
            end
            vd_q <= serial ? ser_place(mix3_q[0], mode_q)
                : par_place(mix3_q[0], mix3_q[1], mix3_q[2], mode_q);
        end
        else if (run_q)
        begin
            vd_valid_q <= 1'b1;
            beat_q <= beat_q + 2'h1;
            run_q <= 32'(beat_q) + 2 < SER_BEATS;
            vd_q <= ser_place(hold_q[beat_q + 2'h1], mode_q);
        end
        else
        begin
            vd_valid_q <= 1'b0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_PAR18_MAP: assert property (v3_q && mode_q == MODE_PAR18 |=>
        vd_q[23:18] == $past(mix3_q[0][7:2]) && vd_q[17:16] == 2'h0 && vd_q[1:0] == 2'h0)
        else $error("18-bit parallel mapping wrong");
    AST_PAR16_MAP: assert property (v3_q && mode_q == MODE_PAR16 |=>
        vd_q[23:19] == $past(mix3_q[0][7:3]) && vd_q[7:3] == $past(mix3_q[2][7:3])
        && vd_q[2:0] == 3'h0)
        else $error("16-bit parallel mapping wrong");
    AST_SER24_SEQ: assert property (v3_q && mode_q == MODE_SER24 ##1 $stable(mode_q) |->
        vd_q == {$past(mix3_q[0]), 16'h0000} ##1 vd_valid_q && vd_q[23:16] == $past(mix3_q[1], 2)
        ##1 vd_valid_q && vd_q[23:16] == $past(mix3_q[2], 3) && vd_q[15:0] == 16'h0000)
        else $error("24-bit serial beats wrong");
    AST_SER18_IDLE: assert property (
        vd_valid_q && mode_q == MODE_SER18 && $stable(mode_q) |-> vd_q[17:0] == 18'h00000)
        else $error("18-bit serial low pins driven");
    AST_CPU18_MAP: assert property (v3_q && mode_q == MODE_CPU18 |=>
        vd_q == {6'h00, $past(mix3_q[0][7:2]), $past(mix3_q[1][7:2]), $past(mix3_q[2][7:2])})
        else $error("18-bit cpu mapping wrong");
    AST_CPU16_MAP: assert property (v3_q && mode_q == MODE_CPU16 |=>
        vd_q[23:18] == 6'h00 && vd_q[12:7] == $past(mix3_q[1][7:2]) && vd_q[1:0] == 2'h0)
        else $error("16-bit cpu mapping wrong");
    AST_PAL_RD: assert property (req && pal_rd && !rd_wait_q |=> !ack_q ##1 ack_q)
        else $error("palette read not answered in two cycles");
    AST_BASE_ONLY: assert property (v2_q && !cov2_q |=> mix3_q[1] == $past(base2_q[1]))
        else $error("uncovered pixel not base colour");
    AST_ALPHA_VALUE_ONE_FULL: assert property (v2_q && cov2_q && oaen2_q && pp_q
        && alpha_value_one_q[0] == 8'hFF |=> mix3_q[0] == $past(ovl2_q[0]))
        else $error("second alpha value not applied");
    AST_NO_PP: assert property (v2_q && cov2_q && !pp_q && alpha_value_zero_q[2] == 8'h00
        |=> mix3_q[2] == $past(base2_q[2]))
        else $error("first alpha value not applied");
    AST_LATENCY: assert property (
        pix_valid && !serial && $stable(mode_q) |-> ##4 vd_valid_q)
        else $error("pixel lost in pipeline");
    AST_VIOL: assert property (
        req && pal_hit && vertical_phase_field == VPH_ACTIVE |=> viol_q)
        else $error("active phase palette access not flagged");

    COV_SERIAL: cover property (v3_q && serial ##1 run_q ##1 run_q);
    COV_PARALLEL: cover property (v3_q && mode_q == MODE_PAR16);
    COV_BLEND_SEL: cover property (v2_q && cov2_q && oaen2_q && pp_q);
    COV_VIOL: cover property (!viol_q ##1 viol_q);
endmodule

// file: verification/lpb_panel_model.sv
// panel side model: latches every beat the stage presents on the video pins
// assumes beats are qualified by the registered valid strobe on the same clock
`timescale 1ns/1ps
module lpb_panel_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [23:0] video_data_pins,
    input wire logic video_data_valid,
    output int beat_count,
    output logic [23:0] last_beat
);
    // a panel only takes data while the strobe is high
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            beat_count <= 0;
            last_beat <= 24'h000000;
        end
        else if (video_data_valid === 1'b1)
        begin
            beat_count <= beat_count + 1;
            last_beat <= video_data_pins;
        end
    end
endmodule

// file: verification/tb_lcd_pixel_palette_blend.sv
// self-checking bench for the palette / blend / pin mapping stage
// assumes the stage top and its package; panel model on the pin side
`timescale 1ns/1ps
`define CK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_lcd_pixel_palette_blend
    import lpb_pkg::*;
;
    logic clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, pix_valid, ovl_cover, video_data_valid;
    logic [ADDR_W-1:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, rd;
    logic [1:0] vertical_phase_field;
    logic [7:0] base_index, ovl_index;
    logic [23:0] vdp, mon_e;
    logic [24:0] pal [2][256];
    logic [23:0] exq [$];
    int n_mismatch, n_checks, n_beats, panel_beats;

    lpb_top DUT (.clk, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
        .wb_dat_r, .wb_ack, .vertical_phase_field, .pix_valid, .base_index, .ovl_index,
        .ovl_cover, .video_data_pins(vdp), .video_data_valid);
    lpb_panel_model PANEL (.clk, .rst_n, .video_data_pins(vdp), .video_data_valid,
        .beat_count(panel_beats), .last_beat());

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #100000;
        n_mismatch++;
        end_sim;
    end

    // one classic cycle; entered right after a rising edge
    task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [31:0] d,
        input logic [3:0] sel, output logic [31:0] q);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= sel;
        wb_dat_w <= d;
        // only the watchdog ends a wait for the answer
        do
        begin
            @(posedge clk);
        end
        while (wb_ack !== 1'b1);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
        `CK("wb ack drop", 1'b0, wb_ack)
    endtask

    function automatic logic [24:0] unpack(input logic [24:0] e, input logic [2:0] f);
        case (f)
            FMT_666: return {e[18], e[17:12], 2'h0, e[11:6], 2'h0, e[5:0], 2'h0};
            FMT_565: return {1'b0, e[15:11], 3'h0, e[10:5], 2'h0, e[4:0], 3'h0};
            FMT_555: return {e[15], e[14:10], 3'h0, e[9:5], 3'h0, e[4:0], 3'h0};
            default: return e;
        endcase
    endfunction

    function automatic logic [7:0] mix(input int b, input int o, input int f);
        int w;
        w = f + f / 128;
        return 8'((b * (256 - w) + o * w) / 256);
    endfunction

    task automatic push_exp(input logic [23:0] c, input logic [2:0] m);
        case (m)
            MODE_PAR18: exq.push_back({c[23:18], 2'h0, c[15:10], 2'h0, c[7:2], 2'h0});
            MODE_PAR16: exq.push_back({c[23:19], 3'h0, c[15:10], 2'h0, c[7:3], 3'h0});
            MODE_SER24: for (int i = 0; i < 3; i++) exq.push_back({c[23-8*i -: 8], 16'h0});
            MODE_SER18: for (int i = 0; i < 3; i++) exq.push_back({c[23-8*i -: 6], 18'h0});
            MODE_CPU18: exq.push_back({6'h0, c[23:18], c[15:10], c[7:2]});
            MODE_CPU16: exq.push_back({6'h0, c[23:19], c[15:10], c[7:3], 2'h0});
            default: exq.push_back(c);
        endcase
        n_beats += (m == MODE_SER24 || m == MODE_SER18) ? SER_BEATS : 1;
    endtask

    always @(posedge clk)
    begin
        if (rst_n && video_data_valid === 1'b1)
        begin
            mon_e = (exq.size() > 0) ? exq.pop_front() : ~vdp;
            `CK("b2", mon_e[23:16], vdp[23:16])
            `CK("b1", mon_e[15:8], vdp[15:8])
            `CK("b0", mon_e[7:0], vdp[7:0])
        end
    end

    initial
    begin
        logic [2:0] fmts [5];
        logic [24:0] be, oe;
        logic [23:0] c, al0, al1, f24;
        logic [31:0] ctrl;
        logic [7:0] bi, oi;
        logic cov;
        logic [2:0] bf, of;
        int gap;
        void'($urandom(91079));
        rst_n = 1'b0;
        {wb_cyc, wb_stb, wb_we, pix_valid, ovl_cover} = 5'h00;
        wb_adr = 12'h000;
        wb_sel = 4'h0;
        wb_dat_w = 32'h00000000;
        vertical_phase_field = 2'h0;
        base_index = 8'h00;
        ovl_index = 8'h00;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (fmts[i])
        begin
            wb_xfer(1'b0, 12'(4 * i), 32'h0, 4'hF, rd);
            `CK("reg reset", 24'h000000, rd[23:0])
        end
        wb_xfer(1'b1, 12'h0F0, 32'hFFFFFFFF, 4'hF, rd);
        wb_xfer(1'b0, 12'h0F0, 32'h0, 4'hF, rd);
        `CK("unmapped", 32'h00000000, rd)
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 256; i++)
            begin
                pal[p][i] = 25'($urandom);
                vertical_phase_field <= 2'($urandom % 2) * 2'h3;
                wb_xfer(1'b1, {p ? PAL_OVL_PAGE : PAL_BASE_PAGE, 8'(i), 2'h0},
                    {7'h0, pal[p][i]}, 4'hF, rd);
            end
        for (int k = 0; k < 4; k++)
        begin
            wb_xfer(1'b0, {k[1] ? PAL_OVL_PAGE : PAL_BASE_PAGE, {8{k[0]}}, 2'h0}, 32'h0,
                4'hF, rd);
            `CK("palette", pal[k[1]][{8{k[0]}}], rd[24:0])
        end
        vertical_phase_field <= VPH_ACTIVE;
        wb_xfer(1'b1, {PAL_BASE_PAGE, 8'h01, 2'h0}, {7'h0, pal[0][1]}, 4'hF, rd);
        wb_xfer(1'b0, OFS_STATUS, 32'h0, 4'hF, rd);
        `CK("status", {1'b1, VPH_ACTIVE}, {rd[STAT_VIOL_BIT], rd[1:0]})
        vertical_phase_field <= 2'h1;
        wb_xfer(1'b1, OFS_STATUS, 32'h100, 4'h2, rd);
        wb_xfer(1'b0, OFS_STATUS, 32'h0, 4'hF, rd);
        `CK("status clr", 3'h1, {rd[STAT_VIOL_BIT], rd[1:0]})
        fmts = '{FMT_888, FMT_666, FMT_565, FMT_555, 3'h7};
        for (int m = 0; m < 7; m++)
            for (int cfg = 0; cfg < 4; cfg++)
            begin
                bf = fmts[(cfg + m) % 5];
                of = fmts[(2 * cfg + m + 1) % 5];
                al0 = (cfg == 3) ? 24'h00FF7F : 24'($urandom);
                // zero blue factor with per-pixel select off keeps base blue
                if (cfg == 2)
                    al0[7:0] = 8'h00;
                al1 = (cfg == 3) ? 24'hFF0080 : 24'($urandom);
                ctrl = 32'(m) | (32'(bf) << CTRL_BFMT_LSB) | (32'(of) << CTRL_OFMT_LSB)
                    | (32'(cfg % 2) << CTRL_PPBLEND_BIT) | (32'(cfg != 0) << CTRL_OVL_EN_BIT);
                wb_xfer(1'b1, OFS_ALPHA_VALUE_ZERO, {8'h0, al0}, 4'hF, rd);
                wb_xfer(1'b1, OFS_ALPHA_VALUE_ONE, {8'h0, al1}, 4'hF, rd);
                wb_xfer(1'b1, OFS_CTRL, ctrl, 4'hF, rd);
                wb_xfer(1'b0, OFS_CTRL, 32'h0, 4'hF, rd);
                `CK("ctrl", ctrl[13:0], rd[13:0])
                for (int p = 0; p < 12; p++)
                begin
                    bi = 8'($urandom);
                    oi = 8'($urandom);
                    cov = ($urandom % 4) != 0;
                    be = unpack(pal[0][bi], bf);
                    oe = unpack(pal[1][oi], of);
                    c = be[23:0];
                    if (cfg != 0 && cov)
                    begin
                        f24 = (cfg % 2 == 1 && oe[24]) ? al1 : al0;
                        for (int ch = 0; ch < 3; ch++)
                            c[8*ch +: 8] = mix(be[8*ch +: 8], oe[8*ch +: 8], f24[8*ch +: 8]);
                    end
                    push_exp(c, 3'(m));
                    pix_valid <= 1'b1;
                    base_index <= bi;
                    ovl_index <= oi;
                    ovl_cover <= cov;
                    @(posedge clk);
                    // serial beats need three slots per pixel
                    gap = (m == MODE_SER24 || m == MODE_SER18) ? 3 : 1;
                    gap += $urandom % 2;
                    if (gap > 1)
                        pix_valid <= 1'b0;
                    repeat (gap - 1) @(posedge clk);
                end
                pix_valid <= 1'b0;
                repeat (12) @(posedge clk);
            end
        `CK("left over", 0, exq.size())
        `CK("panel beats", n_beats, panel_beats)
        end_sim;
    end
endmodule
